// ---- core/eepc_regs.svh ----
// eepc_regs.svh - constants of the serial eeprom command core:
// opcodes, status bit positions, protect codes and timing.
// assumes: included by bare name from the package and core files.
`ifndef EEPC_REGS_SVH
`define EEPC_REGS_SVH

// ------------------------------------------------------------
// instruction opcodes
// ------------------------------------------------------------
`define EEPC_OP_SET_LATCH    8'h06
`define EEPC_OP_CLEAR_LATCH  8'h04
`define EEPC_OP_STATUS_READ  8'h05
`define EEPC_OP_STATUS_WRITE 8'h01
`define EEPC_OP_MEM_READ     8'h03
`define EEPC_OP_MEM_WRITE    8'h02

// ------------------------------------------------------------
// status byte fields
// ------------------------------------------------------------
`define EEPC_SR_LOCK_POS     7
`define EEPC_SR_BPHI_POS     3
`define EEPC_SR_BPLO_POS     2
`define EEPC_SR_LATCH_POS    1
`define EEPC_SR_BUSY_POS     0
`define EEPC_SR_LOCK_RST     1'h0
`define EEPC_SR_BP_RST       2'h0

// ------------------------------------------------------------
// protect codes and geometry
// ------------------------------------------------------------
`define EEPC_BP_NONE         2'h0
`define EEPC_BP_QUARTER      2'h1
`define EEPC_BP_HALF         2'h2
`define EEPC_BP_ALL          2'h3
`define EEPC_ADDR_W          14
`define EEPC_PAGE_BYTES      64

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define EEPC_WRITE_TIME_US   5000
`define EEPC_CLK_MHZ         10
`define EEPC_WRITE_CYCLES    (`EEPC_WRITE_TIME_US * `EEPC_CLK_MHZ)

`endif

// ---- core/eepc_pkg.sv ----
// eepc_pkg.sv - types of the serial eeprom command core.
// assumes: constants come from eepc_regs.svh.
`include "eepc_regs.svh"

package eepc_pkg;

    // frame states, one-hot
    typedef enum logic [9:0] {
        ST_IDLE  = 10'h001, // deselected, waiting for select
        ST_OPC   = 10'h002, // shifting opcode
        ST_ADDR  = 10'h004, // shifting two address bytes
        ST_SRIN  = 10'h008, // shifting new status byte
        ST_SRWT  = 10'h010, // status byte in, waiting for release
        ST_SROUT = 10'h020, // streaming status out
        ST_RDOUT = 10'h040, // streaming memory out
        ST_WRIN  = 10'h080, // loading page bytes
        ST_LTWT  = 10'h100, // latch opcode in, waiting for release
        ST_DEAD  = 10'h200  // ignoring clocks until reselect
    } eepc_state_t;

    // registered state of the core, apart from the array and page buffer
    typedef struct packed {
        logic [4:0]  sy1;    // pin sync stage one
        logic [4:0]  sy2;    // pin sync stage two
        logic [1:0]  prv;    // previous select and clock
        eepc_state_t st;     // frame state
        logic [7:0]  op;     // latched opcode
        logic [7:0]  sh;     // input shifter
        logic [2:0]  bits;   // bit within byte
        logic        abyte;  // second address byte due
        logic [13:0] addr;   // write address
        logic        wrok;   // at least one data byte
        logic [63:0] mask;   // loaded page bytes
        logic        lock;   // status lock bit
        logic [1:0]  bp;     // block protect bits
        logic [2:0]  nv_new; // pending lock and protect
        logic        write_latch_bit;    // write latch
        logic        busy;   // internal write running
        logic        kind;   // 1 memory, 0 status write
        logic [15:0] tmr;    // internal write timer
        logic [6:0]  osh;    // output shifter
        logic [2:0]  ocnt;   // output bit count
        logic [7:0]  f0;     // buffer head
        logic [7:0]  f1;     // buffer tail
        logic [1:0]  fcnt;   // buffer fill
        logic [13:0] raddr;  // read fetch address
        logic        so;     // serial out
        logic        so_oe;  // serial out enable
    } eepc_core_t;

endpackage : eepc_pkg

// ---- core/eepc_core.sv ----
// eepc_core.sv - command core of a 16k x 8 serial eeprom behind a
// four-wire link, modes 0 and 3, with write latch, status byte,
// block protect, hardware lock, hold, page write and sequential read.
// assumes: one 10 MHz clock; all pins are asynchronous to it and the
// link clock is several times slower than clk.
`include "eepc_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module eepc_core #(
    parameter int WRITE_CYCLES = `EEPC_WRITE_CYCLES // internal write length
) (
    input  wire logic clk,    // core clock, 10 MHz
    input  wire logic nrst,   // synchronous reset, active low
    input  wire logic cs_n,   // chip select pin, active low
    input  wire logic sck,    // link clock pin
    input  wire logic si,     // serial data in pin
    input  wire logic wp_n,   // write protect pin, active low
    input  wire logic hold_n, // hold pin, active low
    output var  logic so,     // serial data out
    output var  logic so_oe   // serial out enable, high drives
);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    // memory array and the page being loaded
    logic [7:0] mem  [0:(1 << `EEPC_ADDR_W) - 1];
    logic [7:0] pbuf [0:`EEPC_PAGE_BYTES - 1];

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    eepc_pkg::eepc_core_t r;   // registered state
    eepc_pkg::eepc_core_t n;   // next state

    // page buffer write port
    logic       pb_we;   // write one page byte
    logic [5:0] pb_idx;  // page byte index
    logic [7:0] pb_dat;  // page byte value
    // commit of the page into the array
    logic       commit;  // end of memory write

    // pin views after synchronising
    logic cs_s;     // select level, high deselects
    logic sck_s;    // link clock level
    logic si_s;     // serial data level
    logic wp_s;     // protect pin level
    logic hold_s;   // hold pin level
    logic act;      // selected and not held
    logic cs_fall;  // select just fell
    logic cs_rise;  // select just rose
    logic sck_r;    // usable link clock rise
    logic sck_f;    // usable link clock fall
    logic hwlock;   // hardware lock mode
    logic [7:0] sh_n;    // shifter with new bit
    logic [7:0] stat;    // live status byte
    logic [7:0] ob;      // byte loaded to output
    logic       pop;     // buffer drained this cycle
    logic       fdone;   // timer end this cycle

    // ------------------------------------------------------------
    // protect decode
    // ------------------------------------------------------------
    // the protect ranges fall on page bounds, so testing the
    // current write address in the page covers every byte of it
    function automatic logic prot(input logic [1:0] bp,
                                  input logic [13:0] a);
        logic p;
        p = 1'b0;
        case (bp)
            `EEPC_BP_QUARTER: p = (a[13:12] == 2'h3);
            `EEPC_BP_HALF:    p = a[13];
            `EEPC_BP_ALL:     p = 1'b1;
            default:          p = 1'b0;
        endcase
        return p;
    endfunction : prot

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        n      = r;
        pb_we  = 1'b0;
        pb_idx = r.addr[5:0];
        pb_dat = 8'h00;
        commit = 1'b0;
        pop    = 1'b0;
        ob     = 8'h00;

        // two flops on every pin; only stage two is read
        n.sy1 = {cs_n, sck, si, wp_n, hold_n};
        n.sy2 = r.sy1;
        n.prv = r.sy2[4:3];

        cs_s   = r.sy2[4];
        sck_s  = r.sy2[3];
        si_s   = r.sy2[2];
        wp_s   = r.sy2[1];
        hold_s = r.sy2[0];

        act     = ~cs_s & hold_s;
        cs_fall = ~cs_s & r.prv[1];
        cs_rise = cs_s & ~r.prv[1];
        sck_r   = act & sck_s & ~r.prv[0];
        sck_f   = act & ~sck_s & r.prv[0];

        hwlock = r.lock & ~wp_s;

        // old protect, live latch and busy
        stat = 8'h00;
        stat[`EEPC_SR_LOCK_POS]  = r.lock;
        stat[`EEPC_SR_BPHI_POS]  = r.bp[1];
        stat[`EEPC_SR_BPLO_POS]  = r.bp[0];
        stat[`EEPC_SR_LATCH_POS] = r.write_latch_bit;
        stat[`EEPC_SR_BUSY_POS]  = r.busy;

        sh_n = {r.sh[6:0], si_s};

        // ---- internal write timer ----
        fdone = r.busy & (r.tmr == 16'h0001);
        if (r.busy) begin
            n.tmr = r.tmr - 16'h0001;
        end
        if (fdone) begin
            n.busy = 1'b0;
            n.write_latch_bit  = 1'b0;
            if (r.kind) begin
                commit = 1'b1;
            end else begin
                n.lock = r.nv_new[2];
                n.bp   = r.nv_new[1:0];
            end
        end

        // ---- frame ----
        if (cs_fall) begin
            n.st    = eepc_pkg::ST_OPC;
            n.bits  = 3'h0;
            n.sh    = 8'h00;
            n.ocnt  = 3'h0;
            n.fcnt  = 2'h0;
        end else if (cs_rise) begin
            n.st = eepc_pkg::ST_IDLE;
            case (r.st)
                eepc_pkg::ST_LTWT: begin
                    if (r.op == `EEPC_OP_SET_LATCH) begin
                        n.write_latch_bit = 1'b1;
                    end else begin
                        n.write_latch_bit = 1'b0;
                    end
                end
                eepc_pkg::ST_SRWT: begin
                    n.busy = 1'b1;
                    n.kind = 1'b0;
                    n.tmr  = 16'(WRITE_CYCLES);
                end
                eepc_pkg::ST_WRIN: begin
                    if (r.bits == 3'h0 && r.wrok
                        && !prot(r.bp, r.addr)) begin
                        n.busy = 1'b1;
                        n.kind = 1'b1;
                        n.tmr  = 16'(WRITE_CYCLES);
                    end
                end
                default: begin
                    // reads and cancelled frames end quietly
                end
            endcase
        end else if (sck_r) begin
            n.sh   = sh_n;
            n.bits = 3'(r.bits + 3'h1);
            case (r.st)
                eepc_pkg::ST_OPC: begin
                    if (r.bits == 3'h7) begin
                        n.op = sh_n;
                        case (sh_n)
                            `EEPC_OP_SET_LATCH,
                            `EEPC_OP_CLEAR_LATCH: begin
                                n.st = eepc_pkg::ST_LTWT;
                            end
                            `EEPC_OP_STATUS_READ: begin
                                n.st = eepc_pkg::ST_SROUT;
                            end
                            `EEPC_OP_STATUS_WRITE: begin
                                if (r.write_latch_bit && !r.busy && !hwlock) begin
                                    n.st = eepc_pkg::ST_SRIN;
                                end else begin
                                    n.st = eepc_pkg::ST_DEAD;
                                end
                            end
                            `EEPC_OP_MEM_READ: begin
                                if (r.busy) begin
                                    n.st = eepc_pkg::ST_DEAD;
                                end else begin
                                    n.st    = eepc_pkg::ST_ADDR;
                                    n.abyte = 1'b0;
                                end
                            end
                            `EEPC_OP_MEM_WRITE: begin
                                if (r.write_latch_bit && !r.busy) begin
                                    n.st    = eepc_pkg::ST_ADDR;
                                    n.abyte = 1'b0;
                                end else begin
                                    n.st = eepc_pkg::ST_DEAD;
                                end
                            end
                            default: begin
                                n.st = eepc_pkg::ST_DEAD;
                            end
                        endcase
                    end
                end
                eepc_pkg::ST_ADDR: begin
                    if (r.bits == 3'h7) begin
                        if (!r.abyte) begin
                            n.addr[13:8] = sh_n[5:0];
                            n.abyte      = 1'b1;
                        end else begin
                            n.addr[7:0] = sh_n;
                            n.wrok      = 1'b0;
                            n.mask      = 64'h0;
                            if (r.op == `EEPC_OP_MEM_READ) begin
                                n.st    = eepc_pkg::ST_RDOUT;
                                n.raddr = {r.addr[13:8], sh_n};
                                n.fcnt  = 2'h0;
                            end else begin
                                n.st = eepc_pkg::ST_WRIN;
                            end
                        end
                    end
                end
                eepc_pkg::ST_SRIN: begin
                    if (r.bits == 3'h7) begin
                        // only lock and protect are writable
                        n.nv_new = {sh_n[`EEPC_SR_LOCK_POS],
                                    sh_n[`EEPC_SR_BPHI_POS],
                                    sh_n[`EEPC_SR_BPLO_POS]};
                        n.st     = eepc_pkg::ST_SRWT;
                    end
                end
                eepc_pkg::ST_WRIN: begin
                    if (r.bits == 3'h7) begin
                        // byte goes to the page buffer
                        pb_we  = 1'b1;
                        pb_idx = r.addr[5:0];
                        pb_dat = sh_n;
                        n.mask[r.addr[5:0]] = 1'b1;
                        n.wrok = 1'b1;
                        n.addr[5:0] = 6'(r.addr[5:0] + 6'h01);
                    end
                end
                eepc_pkg::ST_LTWT,
                eepc_pkg::ST_SRWT: begin
                    n.st = eepc_pkg::ST_DEAD;
                end
                default: begin
                    // outputs and dead frames ignore input
                end
            endcase
        end else if (sck_f && (r.st == eepc_pkg::ST_SROUT
                     || r.st == eepc_pkg::ST_RDOUT)) begin
            // next bit on the falling edge
            n.ocnt = 3'(r.ocnt + 3'h1);
            if (r.ocnt == 3'h0) begin
                if (r.st == eepc_pkg::ST_SROUT) begin
                    ob = stat;
                end else begin
                    ob  = r.f0;
                    pop = 1'b1;
                end
                n.so  = ob[7];
                n.osh = ob[6:0];
            end else begin
                n.so  = r.osh[6];
                n.osh = {r.osh[5:0], 1'b0};
            end
        end

        // ---- read buffer ----
        // the fetcher only runs while the buffer has room, so a
        // slow drain stalls it and no fetched byte is dropped
        if (pop) begin
            n.f0   = r.f1;
            n.fcnt = r.fcnt - 2'h1;
        end
        if (r.st == eepc_pkg::ST_RDOUT && n.st == eepc_pkg::ST_RDOUT
            && n.fcnt != 2'h2) begin
            if (n.fcnt == 2'h0) begin
                n.f0 = mem[r.raddr];
            end else begin
                n.f1 = mem[r.raddr];
            end
            n.fcnt = n.fcnt + 2'h1;
            n.raddr = 14'(r.raddr + 14'h0001);
        end

        n.so_oe = ~cs_s & hold_s & (n.st == eepc_pkg::ST_SROUT
                  || n.st == eepc_pkg::ST_RDOUT);

        if (!nrst) begin
            n       = '0;
            n.st    = eepc_pkg::ST_IDLE;
            n.sy1   = 5'h1F;
            n.sy2   = 5'h1F;
            n.prv   = 2'h3;
            n.lock  = `EEPC_SR_LOCK_RST;
            n.bp    = `EEPC_SR_BP_RST;
            n.write_latch_bit   = 1'b0;
            n.busy  = 1'b0;
            n.so    = 1'b1;
            pb_we   = 1'b0;
            commit  = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        r <= n;
    end

    // ------------------------------------------------------------
    // page buffer and array
    // ------------------------------------------------------------
    // the array changes only at commit, so reads during a write
    // are impossible and need no bypass
    always_ff @(posedge clk) begin
        if (pb_we) begin
            pbuf[pb_idx] <= pb_dat;
        end
        if (commit) begin
            for (int i = 0; i < `EEPC_PAGE_BYTES; i++) begin
                if (r.mask[i]) begin
                    mem[{r.addr[13:6], 6'(i)}] <= pbuf[i];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign so    = r.so;
    assign so_oe = r.so_oe;

endmodule : eepc_core

`default_nettype wire

// ---- bench/eepc_core_assertions.sv ----
// eepc_core_assertions.sv - pin-level checker bound to the eeprom core.
// assumes: pins change just after clk rises; link clock far below clk.
`timescale 1ns/1ps
`default_nettype none
module eepc_core_assertions (
    input wire logic clk,    // core clock
    input wire logic nrst,   // reset, active low
    input wire logic cs_n,   // select pin
    input wire logic sck,    // link clock pin
    input wire logic si,     // data in pin
    input wire logic wp_n,   // protect pin
    input wire logic hold_n, // hold pin
    input wire logic so,     // data out
    input wire logic so_oe   // drive enable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    logic       sck_q; // link clock one cycle ago
    logic [6:0] rcnt;  // rises in frame, saturating
    logic [7:0] op;    // opcode seen on the pins
    logic [3:0] fage;  // cycles since link clock fell
    // -------------------------------------------------------------
    // frame tracking from the raw pins
    // -------------------------------------------------------------
    // raw pins lead the core's synced view by a few cycles: bounds allow it
    always_ff @(posedge clk) begin
        sck_q <= sck;
        if (cs_n) rcnt <= 7'h00;
        else if (sck && !sck_q && hold_n && rcnt != 7'h7F) rcnt <= rcnt + 7'h01;
        if (!cs_n && sck && !sck_q && hold_n && rcnt < 7'h08) op <= {op[6:0], si};
        if (!sck && sck_q) fage <= 4'h0;
        else if (fage != 4'hF) fage <= fage + 4'h1;
    end
    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    a_reset_quiet: assert property (disable iff (1'b0) !nrst |=> !so_oe && so)
        else $error("output driven in reset");
    a_desel_float: assert property (cs_n [*6] |-> !so_oe)
        else $error("output driven while deselected");
    a_hold_float: assert property ((!cs_n && !hold_n) [*6] |-> !so_oe)
        else $error("output driven during hold");
    a_out_on_fall: assert property (so_oe && $past(so_oe) && so != $past(so)
        |-> fage inside {[4'h1:4'h6]})
        else $error("output moved away from a clock fall");
    a_oe_after_op: assert property ($rose(so_oe) |-> !cs_n && hold_n && rcnt >= 7'h08)
        else $error("output enabled before opcode");
    a_read_after_addr: assert property ($rose(so_oe) && op == 8'h03 |-> rcnt >= 7'h18)
        else $error("read data before address");
    a_status_streams: assert property ((rcnt == 7'h08 && op == 8'h05 && !cs_n && hold_n)
        [*6] |-> so_oe)
        else $error("status byte not driven");
    a_bad_op_dead: assert property (rcnt >= 7'h09
        && !(op inside {8'h06, 8'h04, 8'h05, 8'h01, 8'h03, 8'h02}) |-> !so_oe)
        else $error("unknown opcode answered");
    a_write_op_silent: assert property (rcnt >= 7'h08
        && op inside {8'h06, 8'h04, 8'h01, 8'h02} |-> !so_oe)
        else $error("write opcode drove output");
    c_status_read: cover property (op == 8'h05 && so_oe);
    c_mem_read: cover property (op == 8'h03 && so_oe);
    c_hold_pause: cover property (!cs_n && !hold_n && rcnt >= 7'h08);
    // status write attempted with the protect pin low
    c_locked_write: cover property (!wp_n && op == 8'h01 && rcnt >= 7'h10);
endmodule : eepc_core_assertions
bind eepc_core eepc_core_assertions eepc_core_assertions_i (
    .clk(clk), .nrst(nrst), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n),
    .hold_n(hold_n), .so(so), .so_oe(so_oe));
`default_nettype wire

// ---- bench/eepc_host.sv ----
// eepc_host.sv - link host model: select, mode 0 clock and data.
// assumes: clk is 10 MHz, so one link clock period is 8 clk cycles.
`timescale 1ns/1ps
`default_nettype none
module eepc_host (
    input  wire logic clk,   // core clock
    input  wire logic so,    // device data out
    input  wire logic so_oe, // device drive enable
    output var  logic cs_n,  // select, active low
    output var  logic sck,   // link clock, still between frames
    output var  logic si     // data to device
);
    logic last = 1'b0; // last level the device drove
    logic miso;        // resolved data line
    // a released line shows the inverse, so a stale bit never matches
    always_ff @(posedge clk) if (so_oe) last <= so;
    assign miso = so_oe ? so : ~last;
    initial begin
        cs_n = 1'b1;
        sck  = 1'b0;
        si   = 1'b1;
    end
    // wait n edges, then step just past the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // select first, msb first, released on the chosen count
    task automatic frame(input int nb, input logic [39:0] tx, output logic [39:0] rx);
        rx   = 40'h0;
        cs_n = 1'b0;
        for (int i = nb - 1; i >= 0; i--) begin
            si = tx[i];
            tick(4);
            sck = 1'b1;
            rx  = {rx[38:0], miso};
            tick(4);
            sck = 1'b0;
        end
        tick(4);
        cs_n = 1'b1;
        tick(6);
    endtask : frame
endmodule : eepc_host
`default_nettype wire

// ---- bench/test_eepc_core.sv ----
// test_eepc_core.sv - self-checking bench for the eeprom command core.
// assumes: host model drives the link; bench drives reset, protect, hold.
`timescale 1ns/1ps
`default_nettype none
module test_eepc_core;
    typedef struct {
        int          nb; // link clocks in the frame
        logic [39:0] tx; // bits sent, last one at bit 0
        logic [1:0]  f;  // bit 0 compare last byte, bit 1 wait idle
        logic [7:0]  eb; // expected last byte
    } eepc_row_t;
    logic        clk, nrst, wp_n, hold_n; // bench driven pins
    logic        cs_n, sck, si, so, so_oe; // link and output
    logic [39:0] rx;                       // bits taken back
    int          err_total, checks_done;   // report counters
    eepc_row_t   rows [37] = '{
        '{16, 40'h0500, 2'h1, 8'h00},
        '{8, 40'h06, 2'h0, 8'h00}, '{16, 40'h0500, 2'h1, 8'h02},
        '{9, 40'h008, 2'h0, 8'h00}, '{16, 40'h0500, 2'h1, 8'h02},
        '{8, 40'h04, 2'h0, 8'h00}, '{16, 40'h0500, 2'h1, 8'h00},
        '{8, 40'h06, 2'h0, 8'h00}, '{40, 40'h02007FAABB, 2'h0, 8'h00},
        '{16, 40'h0500, 2'h3, 8'h03}, '{16, 40'h0500, 2'h1, 8'h00},
        '{32, 40'h03C07F00, 2'h1, 8'hAA}, '{32, 40'h03004000, 2'h1, 8'hBB},
        '{32, 40'h02004055, 2'h0, 8'h00}, '{16, 40'h0500, 2'h1, 8'h00},
        '{8, 40'h06, 2'h0, 8'h00}, '{36, 40'h20040330, 2'h0, 8'h00},
        '{16, 40'h0500, 2'h1, 8'h02},
        '{17, 40'h0218, 2'h0, 8'h00}, '{16, 40'h0500, 2'h1, 8'h02},
        '{32, 40'h03004000, 2'h1, 8'hBB},
        '{16, 40'h010C, 2'h0, 8'h00}, '{16, 40'h0500, 2'h3, 8'h03},
        '{16, 40'h0500, 2'h1, 8'h0C},
        '{8, 40'h06, 2'h0, 8'h00}, '{32, 40'h02004077, 2'h0, 8'h00},
        '{16, 40'h0500, 2'h1, 8'h0E},
        '{16, 40'h0104, 2'h0, 8'h00}, '{16, 40'h0500, 2'h3, 8'h0F},
        '{8, 40'h06, 2'h0, 8'h00}, '{32, 40'h02004066, 2'h0, 8'h00},
        '{16, 40'h0500, 2'h3, 8'h07}, '{32, 40'h03004000, 2'h1, 8'h66},
        '{8, 40'h06, 2'h0, 8'h00}, '{32, 40'h02300099, 2'h0, 8'h00},
        '{16, 40'h0500, 2'h1, 8'h06},
        '{16, 40'hAB00, 2'h0, 8'h00}};
    // internal write must outlast one status poll so busy can be seen
    eepc_core #(.WRITE_CYCLES(400)) eepc_core_i (
        .clk(clk), .nrst(nrst), .cs_n(cs_n), .sck(sck), .si(si),
        .wp_n(wp_n), .hold_n(hold_n), .so(so), .so_oe(so_oe));
    eepc_host eepc_host_i (
        .clk(clk), .so(so), .so_oe(so_oe), .cs_n(cs_n), .sck(sck), .si(si));
    // -------------------------------------------------------------
    // clock and shared tasks
    // -------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : wrap_up
    // one frame, optional compare, optional bounded wait for idle
    task automatic run(input int nb, input logic [39:0] tx, input logic [1:0] f,
                       input logic [7:0] eb);
        bit idle;
        idle = 1'b0;
        eepc_host_i.frame(nb, tx, rx);
        if (f[0]) check(rx[7:0], eb);
        for (int k = 0; k < 30 && f[1] && !idle; k++) begin
            eepc_host_i.frame(16, 40'h0500, rx);
            idle = (rx[0] === 1'b0);
        end
        if (f[1] && !idle) begin
            err_total++;
            $display("BAD %0t write never ended", $time);
            wrap_up();
        end
    endtask : run
    // -------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------
    initial begin
        nrst = 1'b0;
        wp_n = 1'b1;
        hold_n = 1'b1;
        err_total = 0;
        checks_done = 0;
        repeat (12) @(posedge clk);
        #1 nrst = 1'b1;
        eepc_host_i.tick(4);
        foreach (rows[i]) run(rows[i].nb, rows[i].tx, rows[i].f, rows[i].eb);
        // lock bit with protect pin low must block status writes
        run(16, 40'h0180, 2'h2, 8'h00);
        wp_n = 1'b0;
        run(8, 40'h06, 2'h0, 8'h00);
        run(16, 40'h010C, 2'h0, 8'h00);
        run(16, 40'h0500, 2'h1, 8'h82);
        wp_n = 1'b1;
        run(16, 40'h0100, 2'h2, 8'h00);
        run(16, 40'h0500, 2'h1, 8'h00);
        // hold in mid stream releases the output
        fork
            eepc_host_i.frame(40, 40'h0500000000, rx);
            begin
                eepc_host_i.tick(150);
                check({7'h00, so_oe}, 8'h01);
                hold_n = 1'b0;
                eepc_host_i.tick(8);
                check({7'h00, so_oe}, 8'h00);
                hold_n = 1'b1;
                eepc_host_i.tick(8);
                check({7'h00, so_oe}, 8'h01);
            end
        join
        // read while an internal write runs must stay silent
        run(8, 40'h06, 2'h0, 8'h00);
        run(16, 40'h0100, 2'h0, 8'h00);
        fork
            eepc_host_i.frame(32, 40'h03004000, rx);
            begin
                eepc_host_i.tick(240);
                check({7'h00, so_oe}, 8'h00);
            end
        join
        run(16, 40'h0500, 2'h2, 8'h00);
        // second reset in mid run clears the latch
        run(8, 40'h06, 2'h0, 8'h00);
        nrst = 1'b0;
        eepc_host_i.tick(12);
        nrst = 1'b1;
        eepc_host_i.tick(4);
        run(16, 40'h0500, 2'h1, 8'h00);
        wrap_up();
    end
endmodule : test_eepc_core
`default_nettype wire
